// File: tks_pkg.sv
// Constants, register map and field layout of the touch key readout block
package tks_pkg;

  localparam int ADDR_W = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_IRQ_EN_MAIN = 8'ha8;
  localparam logic [7:0] IDX_IRQ_EN_EXTRA = 8'ha9;
  localparam logic [7:0] IDX_SHARED_LOW = 8'haa;
  localparam logic [7:0] IDX_CONV_HIGH = 8'hab;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hac;
  localparam logic [7:0] IDX_CAP_TRIM = 8'had;
  localparam logic [7:0] IDX_TOUCH_CTRL = 8'hae;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hc0;
  localparam logic [7:0] IDX_EVENT_MASK = 8'hc1;

  // Field positions
  localparam int CTL_PD_BIT = 7;
  localparam int CTL_EOC_BIT = 6;
  localparam int CTL_LDO_BIT = 5;
  localparam int CHS_W = 5;
  localparam int TRIM_W = 7;
  localparam int IE_GLOBAL_BIT = 7;
  localparam int IE1_CONV_TOUCH_BIT = 3;
  localparam int EV_TOUCH_BIT = 0;
  localparam int EV_CONV_BIT = 1;
  localparam int EV_W = 2;

  // Reset values
  localparam logic CTL_PD_RST = 1'b1;
  localparam logic CTL_EOC_RST = 1'b1;
  localparam logic CTL_LDO_RST = 1'b0;
  localparam logic [4:0] CHS_RST = 5'h0f;
  localparam logic [6:0] TRIM_RST = 7'h40;
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [1:0] EV_RST = 2'h0;

  // Channel codes
  localparam logic [4:0] CHS_REF_KEY = 5'h0f;
  localparam logic [4:0] CHS_LAST_PAD = 5'h13;
  localparam int NUM_PADS = 20;

  // Measurement gate timing
  localparam int CNT_W = 12;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WIN_BASE_NS = 4096;
  localparam int WIN_STEP_NS = 64;
  localparam int WIN_BASE_CYC = (WIN_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_STEP_CYC = (WIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: tks_meas_if.sv
// Handshake between the register front end and the measurement counter
`timescale 1ns/1ns
`default_nettype none
interface tks_meas_if;
  logic start;
  logic abort;
  logic [6:0] trim;
  logic done;
  logic busy;
  logic [11:0] count;
  modport ctrl (output start, output abort, output trim, input done, input busy, input count);
  modport meas (input start, input abort, input trim, output done, output busy, output count);
endinterface
`default_nettype wire

// File: tks_meas.sv
// Counts pad oscillator edges over a gate whose length follows the trim
`timescale 1ns/1ns
`default_nettype none
module tks_meas #(
  parameter int unsigned BASE_CYC = tks_pkg::WIN_BASE_CYC,
  parameter int unsigned STEP_CYC = tks_pkg::WIN_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pad oscillator
  input wire logic osc_pin,
  // Front end
  tks_meas_if.meas m
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } tks_meas_state_t;

  tks_meas_state_t state_q;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [11:0] win_q;
  logic [11:0] cnt_q;
  logic done_q;
  logic gate_end;

  assign gate_end = (state_q == ST_RUN) && (win_q == 12'h000) && !m.start && !m.abort;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || m.abort) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (m.start) state_q <= ST_RUN;
        ST_RUN: if (gate_end) state_q <= ST_DONE;
        ST_DONE: state_q <= m.start ? ST_RUN : ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Longer gate for a larger trim, so the count grows with it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_q <= 12'h000;
    end else if (m.start) begin
      win_q <= 12'(BASE_CYC) + 12'(m.trim) * 12'(STEP_CYC);
    end else if (state_q == ST_RUN && win_q != 12'h000) begin
      win_q <= win_q - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 12'h000;
    end else if (m.start) begin
      cnt_q <= 12'h000;
    end else if (state_q == ST_RUN && osc_s2_q && !osc_s3_q && cnt_q != 12'hfff) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= gate_end;
    end
  end

  assign m.done = done_q;
  assign m.busy = (state_q == ST_RUN);
  assign m.count = cnt_q;

endmodule
`default_nettype wire

// File: tks_top.sv
// Touch key readout: APB registers, channel decode, count capture and interrupt
`timescale 1ns/1ns
`default_nettype none
module tks_top #(
  parameter int unsigned WIN_BASE_CYC = tks_pkg::WIN_BASE_CYC,
  parameter int unsigned WIN_STEP_CYC = tks_pkg::WIN_STEP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tks_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Touch pads
  input wire logic TOUCH_OSC_IN,
  output logic TOUCH_PWR_EN,
  output logic TOUCH_LDO_HIGH,
  output logic [tks_pkg::NUM_PADS-1:0] TOUCH_PAD_SEL,
  output logic TOUCH_REF_SEL,
  // Converter result, same clock
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  // Interrupt
  output logic IRQ
);

  // Byte addresses
  localparam logic [11:0] ADR_IE_MAIN = {2'b00, tks_pkg::IDX_IRQ_EN_MAIN, 2'b00};
  localparam logic [11:0] ADR_IE_EXTRA = {2'b00, tks_pkg::IDX_IRQ_EN_EXTRA, 2'b00};
  localparam logic [11:0] ADR_SHARED = {2'b00, tks_pkg::IDX_SHARED_LOW, 2'b00};
  localparam logic [11:0] ADR_CONV_HI = {2'b00, tks_pkg::IDX_CONV_HIGH, 2'b00};
  localparam logic [11:0] ADR_CNT_LO = {2'b00, tks_pkg::IDX_COUNT_LOW, 2'b00};
  localparam logic [11:0] ADR_TRIM = {2'b00, tks_pkg::IDX_CAP_TRIM, 2'b00};
  localparam logic [11:0] ADR_CTRL = {2'b00, tks_pkg::IDX_TOUCH_CTRL, 2'b00};
  localparam logic [11:0] ADR_STATUS = {2'b00, tks_pkg::IDX_EVENT_STATUS, 2'b00};
  localparam logic [11:0] ADR_MASK = {2'b00, tks_pkg::IDX_EVENT_MASK, 2'b00};

  tks_meas_if meas_if ();

  // Register state
  logic [7:0] ie_main_q;
  logic [7:0] ie_extra_q;
  logic pd_q;
  logic eoc_q;
  logic eoc_d;
  logic ldo_q;
  logic [4:0] chs_q;
  logic [6:0] trim_q;
  logic [11:0] count_q;
  logic [11:0] conv_q;
  logic [1:0] ev_status_q;
  logic [1:0] ev_mask_q;
  logic done_pend_q;
  logic start_q;

  // Bus state
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic access;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic hit;
  logic wr_ie_main;
  logic wr_ie_extra;
  logic wr_trim;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // Outputs from flops
  logic pwr_en_q;
  logic ldo_out_q;
  logic [tks_pkg::NUM_PADS-1:0] pad_sel_q;
  logic ref_sel_q;
  logic irq_q;

  // Access phase takes two cycles: PREADY rises at its first edge
  assign access = PSEL && PENABLE && !pready_q;
  assign wr_en = PSEL && PENABLE && pready_q && PWRITE && PSTRB[0] && !pslverr_q;
  assign wbyte = PWDATA[7:0];

  // One write strobe per writable register
  assign wr_ie_main = wr_en && (PADDR == ADR_IE_MAIN);
  assign wr_ie_extra = wr_en && (PADDR == ADR_IE_EXTRA);
  assign wr_trim = wr_en && (PADDR == ADR_TRIM);
  assign wr_ctrl = wr_en && (PADDR == ADR_CTRL);
  assign wr_status = wr_en && (PADDR == ADR_STATUS);
  assign wr_mask = wr_en && (PADDR == ADR_MASK);

  // Read mux and address decode
  always_comb begin
    rd_byte = 8'h00;
    hit = 1'b1;
    case (PADDR)
      ADR_IE_MAIN: rd_byte = ie_main_q;
      ADR_IE_EXTRA: rd_byte = ie_extra_q;
      ADR_SHARED: rd_byte = {conv_q[3:0], count_q[11:8]};
      ADR_CONV_HI: rd_byte = conv_q[11:4];
      ADR_CNT_LO: rd_byte = count_q[7:0];
      ADR_TRIM: rd_byte = {1'b0, trim_q};
      ADR_CTRL: rd_byte = {pd_q, eoc_q, ldo_q, chs_q};
      ADR_STATUS: rd_byte = {6'h00, ev_status_q};
      ADR_MASK: rd_byte = {6'h00, ev_mask_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access;
    end
  end

  // An unmapped address answers with an error and zero data
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= access && !hit;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      prdata_q <= 32'h0000_0000;
    end else if (access && !PWRITE) begin
      prdata_q <= {24'h000000, rd_byte};
    end else if (access) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Interrupt enable registers; only the gate bits act, the rest is storage
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ie_main_q <= tks_pkg::IE_RST;
    end else if (wr_ie_main) begin
      ie_main_q <= wbyte;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ie_extra_q <= tks_pkg::IE_RST;
    end else if (wr_ie_extra) begin
      ie_extra_q <= wbyte;
    end
  end

  // Control fields; bit 6 is read-only and ignored on write
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pd_q <= tks_pkg::CTL_PD_RST;
    end else if (wr_ctrl) begin
      pd_q <= wbyte[tks_pkg::CTL_PD_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ldo_q <= tks_pkg::CTL_LDO_RST;
    end else if (wr_ctrl) begin
      ldo_q <= wbyte[tks_pkg::CTL_LDO_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      chs_q <= tks_pkg::CHS_RST;
    end else if (wr_ctrl) begin
      chs_q <= wbyte[tks_pkg::CHS_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      trim_q <= tks_pkg::TRIM_RST;
    end else if (wr_trim) begin
      trim_q <= wbyte[tks_pkg::TRIM_W-1:0];
    end
  end

  // A control write with power-down clear starts a measurement
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_ctrl && !wbyte[tks_pkg::CTL_PD_BIT];
    end
  end

  assign meas_if.start = start_q;
  assign meas_if.abort = pd_q;
  assign meas_if.trim = trim_q;

  tks_meas #(
    .BASE_CYC(WIN_BASE_CYC),
    .STEP_CYC(WIN_STEP_CYC)
  ) u_meas (
    .clk(CLK),
    .rstn(RSTN),
    .osc_pin(TOUCH_OSC_IN),
    .m(meas_if.meas)
  );

  // Count is captured one cycle before the done flag rises
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      done_pend_q <= 1'b0;
    end else begin
      done_pend_q <= meas_if.done && !start_q && !pd_q;
    end
  end

  // A result cut short by a restart or power-down is not kept
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      count_q <= 12'h000;
    end else if (meas_if.done && !start_q && !pd_q) begin
      count_q <= meas_if.count;
    end
  end

  // Power-down ends any measurement and leaves the flag set
  always_comb begin
    eoc_d = eoc_q;
    if (start_q) begin
      eoc_d = 1'b0;
    end else if (done_pend_q || pd_q) begin
      eoc_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      eoc_q <= tks_pkg::CTL_EOC_RST;
    end else begin
      eoc_q <= eoc_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      conv_q <= 12'h000;
    end else if (ADC_DONE) begin
      conv_q <= ADC_DATA;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ev_status_q <= tks_pkg::EV_RST;
    end else begin
      for (int i = 0; i < tks_pkg::EV_W; i++) begin
        if (wr_status && wbyte[i]) begin
          ev_status_q[i] <= 1'b0;
        end
      end
      if (eoc_d && !eoc_q) begin
        ev_status_q[tks_pkg::EV_TOUCH_BIT] <= 1'b1;
      end
      if (ADC_DONE) begin
        ev_status_q[tks_pkg::EV_CONV_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ev_mask_q <= tks_pkg::EV_RST;
    end else if (wr_mask) begin
      ev_mask_q <= wbyte[tks_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ie_main_q[tks_pkg::IE_GLOBAL_BIT]
        && ie_extra_q[tks_pkg::IE1_CONV_TOUCH_BIT]
        && |(ev_status_q & ev_mask_q);
    end
  end

  // Pad side controls
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pwr_en_q <= 1'b0;
    end else begin
      pwr_en_q <= !pd_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ldo_out_q <= 1'b0;
    end else begin
      ldo_out_q <= ldo_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ref_sel_q <= 1'b0;
    end else begin
      ref_sel_q <= (chs_q == tks_pkg::CHS_REF_KEY);
    end
  end

  // Codes past the last pad and the reference key select no pad
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pad_sel_q <= '0;
    end else begin
      for (int p = 0; p < tks_pkg::NUM_PADS; p++) begin
        pad_sel_q[p] <= (chs_q == 5'(p)) && (chs_q != tks_pkg::CHS_REF_KEY)
          && (chs_q <= tks_pkg::CHS_LAST_PAD);
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign TOUCH_PWR_EN = pwr_en_q;
  assign TOUCH_LDO_HIGH = ldo_out_q;
  assign TOUCH_PAD_SEL = pad_sel_q;
  assign TOUCH_REF_SEL = ref_sel_q;
  assign IRQ = irq_q;

endmodule
`default_nettype wire

// File: tks_pads.sv
// Pad oscillator model for the touch readout
`timescale 1ns/1ns
`default_nettype none
module tks_pads (
  // Unit controls
  input wire logic pwr_en,
  input wire logic [19:0] pad_sel,
  input wire logic ref_sel,
  // Oscillator
  output logic osc
);
  // Runs only while powered with a key selected, unrelated to the clock
  initial begin
    osc = 1'b0;
    forever begin
      #15;
      osc = (pwr_en && (|pad_sel || ref_sel)) ? !osc : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tks_props.sv
// Port checker for the touch readout
`timescale 1ns/1ns
`default_nettype none
module tks_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tks_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  // Touch unit, converter, interrupt
  input wire logic TOUCH_PWR_EN,
  input wire logic TOUCH_LDO_HIGH,
  input wire logic [19:0] TOUCH_PAD_SEL,
  input wire logic TOUCH_REF_SEL,
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  input wire logic IRQ
);
  logic wr, rd, ie_q, ie1_q;
  logic [7:0] ctl_q;
  logic [6:0] trim_q;
  logic [11:0] adc_q;
  logic [19:0] pad_x;
  assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  assign rd = PSEL && PENABLE && PREADY && !PWRITE;
  assign pad_x = (ctl_q[4:0] < 5'h14 && ctl_q[4:0] != 5'h0f) ? 20'h1 << ctl_q[4:0] : 20'h0;
  // Shadow of what software last wrote, and of the last converter result
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctl_q <= 8'h8f;
      trim_q <= 7'h40;
      ie_q <= 1'b0;
      ie1_q <= 1'b0;
      adc_q <= 12'h000;
    end else begin
      if (wr && PADDR == 12'h2b8) ctl_q <= PWDATA[7:0];
      if (wr && PADDR == 12'h2b4) trim_q <= PWDATA[6:0];
      if (wr && PADDR == 12'h2a0) ie_q <= PWDATA[7];
      if (wr && PADDR == 12'h2a4) ie1_q <= PWDATA[3];
      if (ADC_DONE) adc_q <= ADC_DATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_PWR_LDO: assert property (wr && PADDR == 12'h2b8 |->
    ##2 TOUCH_PWR_EN == !ctl_q[7] && TOUCH_LDO_HIGH == ctl_q[5]) else $error("power or ldo");
  AST_PAD_SEL: assert property (wr && PADDR == 12'h2b8 |->
    ##2 TOUCH_PAD_SEL == pad_x && TOUCH_REF_SEL == (ctl_q[4:0] == 5'h0f)) else $error("pad");
  AST_EOC_IDLE: assert property (rd && PADDR == 12'h2b8 && !TOUCH_PWR_EN &&
    !$past(TOUCH_PWR_EN, 2) |-> PRDATA[7:6] == 2'b11) else $error("done flag");
  AST_CTL_RD: assert property (rd && PADDR == 12'h2b8 |->
    PRDATA[5:0] == ctl_q[5:0]) else $error("control read");
  AST_TRIM_RD: assert property (rd && PADDR == 12'h2b4 |->
    PRDATA[7:0] == {1'b0, trim_q}) else $error("trim read");
  AST_ADC_RD: assert property (rd && PADDR == 12'h2ac |->
    PRDATA[7:0] == $past(adc_q[11:4])) else $error("result read");
  AST_IRQ_GLB: assert property ($past(!ie_q) |-> !IRQ) else $error("global gate");
  AST_IRQ_SRC: assert property ($past(!ie1_q) |-> !IRQ) else $error("source gate");
endmodule
bind tks_top tks_props u_props (.*);
`default_nettype wire

// File: touch_key_sense_readout_bench.sv
// Self-checking bench for the touch readout
`timescale 1ns/1ns
`default_nettype none
module touch_key_sense_readout_bench;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, adc_done, pwr, ldo, refk, osc, irq;
  logic [11:0] paddr, adc_data, av;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [19:0] pad;
  logic [7:0] rd, lo;
  logic [7:0] mdl [int];
  int num_errors, comparisons, cnt, prev, n;
  tks_top #(.WIN_BASE_CYC(16), .WIN_STEP_CYC(1)) DUT (.CLK(clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TOUCH_OSC_IN(osc),
    .TOUCH_PWR_EN(pwr), .TOUCH_LDO_HIGH(ldo), .TOUCH_PAD_SEL(pad), .TOUCH_REF_SEL(refk),
    .ADC_DONE(adc_done), .ADC_DATA(adc_data), .IRQ(irq));
  tks_pads u_pads (.pwr_en(pwr), .pad_sel(pad), .ref_sel(refk), .osc(osc));
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    bit plain;
    plain = a inside {12'h2a0, 12'h2a4, 12'h2b4, 12'h304};
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata[7:0];
    chk(pslverr, mdl.exists(a) ? 0 : 1);
    if (w && pstrb[0] && plain) mdl[a] = (a == 12'h2b4) ? (d & 8'h7f) : d;
    if (!w && plain) chk(rd, mdl[a]);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, adc_done, paddr, pwdata, adc_data} = '0;
    pstrb = 4'hf;
    num_errors = 0;
    comparisons = 0;
    for (int i = 0; i < 7; i++) mdl[12'h2a0 + 4 * i] = 8'h00;
    mdl[12'h2b4] = 8'h40;
    mdl[12'h2b8] = 8'hcf;
    mdl[12'h300] = 8'h00;
    mdl[12'h304] = 8'h00;
    prev = $urandom(7087);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    pstrb <= 4'h0;
    apb(1'b1, 12'h2a0, 8'hff);
    pstrb <= 4'hf;
    apb(1'b1, 12'h2a8, 8'hff);
    apb(1'b1, 12'h2b0, 8'hff);
    apb(1'b0, 12'h3fc, 8'h00);
    foreach (mdl[a]) begin
      apb(1'b0, a[11:0], 8'h00);
      chk(rd, mdl[a]);
    end
    for (int k = 0; k < 32; k++) begin
      lo = 8'(k) | (k[0] ? 8'h20 : 8'h00);
      apb(1'b1, 12'h2b8, lo | 8'h80);
      repeat (2) @(posedge clk);
      chk({pwr, ldo, refk}, {1'b0, k[0], k == 15});
      chk(pad, (k < 20 && k != 15) ? 20'h1 << k : 20'h0);
      apb(1'b0, 12'h2b8, 8'h00);
      chk(rd, lo | 8'hc0);
    end
    apb(1'b1, 12'h2a0, 8'h80);
    apb(1'b1, 12'h2a4, 8'h08);
    apb(1'b1, 12'h304, 8'h03);
    prev = -1;
    for (int t = 0; t < 128; t += 127) begin
      apb(1'b1, 12'h2b4, 8'(t));
      apb(1'b0, 12'h2b4, 8'h00);
      apb(1'b1, 12'h300, 8'h03);
      apb(1'b1, 12'h2b8, 8'h00);
      apb(1'b0, 12'h2b8, 8'h00);
      chk({pwr, rd[7:6]}, 3'b100);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (n >= 400) begin
        num_errors++;
        report_and_stop();
      end
      apb(1'b0, 12'h2b8, 8'h00);
      chk(rd[6], 1'b1);
      apb(1'b0, 12'h2a8, 8'h00);
      lo = rd;
      apb(1'b0, 12'h2b0, 8'h00);
      cnt = {lo[3:0], rd};
      n = (16 + t) * 8 / 30;
      chk(cnt > prev && cnt >= n - 3 && cnt <= n + 3, 1);
      prev = cnt;
    end
    apb(1'b1, 12'h2b8, 8'h00);
    apb(1'b1, 12'h2b8, 8'h80);
    apb(1'b0, 12'h2b8, 8'h00);
    chk(rd, 8'hc0);
    apb(1'b0, 12'h2b0, 8'h00);
    chk(rd, 8'(cnt));
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, 12'h2a0, g[1] ? 8'h80 : 8'h00);
      apb(1'b1, 12'h2a4, g[0] ? 8'h08 : 8'h00);
      repeat (2) @(posedge clk);
      chk(irq, g == 3);
    end
    apb(1'b1, 12'h304, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h304, 8'h03);
    apb(1'b1, 12'h300, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    repeat (3) begin
      av = 12'($urandom);
      adc_data <= av;
      adc_done <= 1'b1;
      @(posedge clk);
      adc_done <= 1'b0;
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b0, 12'h2ac, 8'h00);
      chk(rd, av[11:4]);
      apb(1'b0, 12'h2a8, 8'h00);
      chk(rd, {av[3:0], 4'(cnt >> 8)});
      apb(1'b0, 12'h2b0, 8'h00);
      chk(rd, 8'(cnt));
      apb(1'b1, 12'h300, 8'h02);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
